// ==== core/sqt_top.sv ====
/*
  scope trigger qualifier: sweep sequencing, pattern trigger, trigger type
  and source selection, width, interval and dropout qualifiers, holdoff.
  assumes comparator outputs arrive asynchronously and that channel-on
  flags and the register port are on clk_sys_in.
*/
`timescale 1ns/1ps
`include "sqt_regs.svh"
module sqt_top
#(
  parameter logic [31:0] AUTO_WAIT_CYC = `SQT_AUTO_WAIT_CYC
)
(
  input wire logic clk_sys_in, // system clock, 200 MHz
  input wire logic srst_in, // synchronous reset, high
  input wire logic [3:0] chan_above_in, // comparator above threshold
  input wire logic [3:0] chan_on_in, // channel switched on
  input wire logic line_in, // power line reference
  input wire logic aux_in, // aux trigger input
  input wire logic [7:0] addr_in, // register byte address
  input wire logic [31:0] wr_data_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [31:0] rd_data_out, // read data, cycle after strobe
  output sqt_pkg::sqt_run_t run_state_out, // reported run state
  output logic single_led_out, // single indicator
  output logic acquiring_out, // acquisition running
  output logic capture_out, // one-cycle record capture
  output logic record_valid_out, // a record is on show
  output logic irq_out // level interrupt
);
  import sqt_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  sqt_sweep_t sweep_r, sweep_nxt;
  sqt_type_t type_r, type_nxt;
  sqt_src_t src_r, src_nxt;
  sqt_kind_t kind_r, kind_nxt;
  logic [31:0] lim1_r, lim1_nxt, lim2_r, lim2_nxt;
  logic [7:0] pat_r, pat_nxt;
  sqt_logic_t cond_r, cond_nxt;
  logic [3:0] ist_r, ist_nxt, imask_r, imask_nxt;
  logic [31:0] rd_data_r, rd_data_nxt;
  sqt_run_t run_r, run_nxt;
  logic [31:0] idle_r, idle_nxt;
  logic [31:0] meas_r, meas_nxt, hold_r, hold_nxt;
  logic drop_done_r, drop_done_nxt, pat_prev_r, pat_prev_nxt;
  logic [2:0] div5_r, div5_nxt;
  logic capture_r, capture_nxt, recv_r, recv_nxt;
  logic [5:0] pin_raw;
  logic [5:0] lvl, rise, fall;
  logic sel_lvl, sel_rise, sel_fall, aux5_rise;
  logic [31:0] l1_ns, l2_ns, meas_inc;
  logic [3:0] care, match;
  logic pat_now, cand, fire, qual, auto_tick, reject;
  logic [3:0] ev;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // channels 0..3, then line and aux
  assign pin_raw = {aux_in, line_in, chan_above_in};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_sync
      sqt_sync u_sync
      (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .async_in(pin_raw[gi]),
        .level_out(lvl[gi]),
        .rise_out(rise[gi]),
        .fall_out(fall[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // time conversion
  // ****************************************************************
  // mantissa times unit, clamped to the range of the trigger type
  function automatic logic [31:0] to_ns(input logic [31:0] raw,
    input logic is_edge);
    logic [63:0] mul;
    logic [63:0] v;
    logic [63:0] lo;
    logic [63:0] hi;
    mul = `SQT_NS_PER_S; // no suffix reads as seconds
    case (sqt_unit_t'(raw[`SQT_LIM_UNIT_HI:`SQT_LIM_UNIT_LO]))
      SQT_UNIT_MS: mul = `SQT_NS_PER_MS;
      SQT_UNIT_US: mul = `SQT_NS_PER_US;
      SQT_UNIT_NS: mul = 64'd1;
      default: mul = `SQT_NS_PER_S;
    endcase
    v = {48'h0, raw[`SQT_LIM_MANT_HI:0]} * mul;
    lo = is_edge ? `SQT_EDGE_MIN_NS : `SQT_OTHER_MIN_NS;
    hi = is_edge ? `SQT_EDGE_MAX_NS : `SQT_OTHER_MAX_NS;
    if (v < lo)
      v = lo;
    if (v > hi)
      v = hi;
    return v[31:0];
  endfunction

  // four comparisons shared by pulse and interval kinds
  function automatic logic cmp(input sqt_kind_t k, input logic [31:0] m,
    input logic [31:0] a, input logic [31:0] b);
    logic r;
    r = 1'b0;
    case (k)
      SQT_KD_PULSE_SHORTER, SQT_KD_GAP_SHORTER: r = m < a;
      SQT_KD_PULSE_LONGER, SQT_KD_GAP_LONGER: r = m > a;
      SQT_KD_PULSE_WITHIN, SQT_KD_GAP_WITHIN: r = (m > a) && (m < b);
      SQT_KD_PULSE_OUTSIDE, SQT_KD_GAP_OUTSIDE: r = (m < a) || (m > b);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  assign l1_ns = to_ns(lim1_r, type_r == SQT_TY_EDGE);
  assign l2_ns = to_ns(lim2_r, type_r == SQT_TY_EDGE);

  // ****************************************************************
  // source selection and pattern
  // ****************************************************************
  // aux divided by five counts settled rising edges
  assign aux5_rise = rise[5] && (div5_r == 3'h4);

  always_comb
  begin
    sel_lvl = 1'b0;
    sel_rise = 1'b0;
    sel_fall = 1'b0;
    case (src_r)
      SQT_SRC_LINE:
      begin
        sel_lvl = lvl[4];
        sel_rise = rise[4];
        sel_fall = fall[4];
      end
      SQT_SRC_AUX:
      begin
        sel_lvl = lvl[5];
        sel_rise = rise[5];
        sel_fall = fall[5];
      end
      SQT_SRC_AUX_DIV5: sel_rise = aux5_rise;
      default:
      begin
        sel_lvl = lvl[src_r[1:0]];
        sel_rise = rise[src_r[1:0]];
        sel_fall = fall[src_r[1:0]];
      end
    endcase
  end

  // per-channel match, then the selected logic over cared channels
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      care[i] = sqt_lvl_t'(pat_r[2*i +: 2]) != SQT_LV_DONT_CARE;
      match[i] = (sqt_lvl_t'(pat_r[2*i +: 2]) == SQT_LV_HIGH) ?
        lvl[i] : ~lvl[i];
    end
    unique case (cond_r)
      SQT_LG_OR: pat_now = |(match & care);
      SQT_LG_NAND: pat_now = ~&(match | ~care);
      default: pat_now = &(match | ~care);
    endcase
    pat_now = pat_now & (|care);
  end

  // ****************************************************************
  // trigger qualification
  // ****************************************************************
  // candidate event per trigger type
  assign meas_inc = (meas_r > 32'hffff_ffff - `SQT_CLK_NS) ? 32'hffff_ffff :
    meas_r + `SQT_CLK_NS;
  assign qual = cmp(kind_r, meas_r, l1_ns, l2_ns);

  always_comb
  begin
    unique case (type_r)
      SQT_TY_EDGE: cand = sel_rise;
      SQT_TY_EDGE_RATE, SQT_TY_GAP: cand = sel_rise & qual;
      SQT_TY_WIDTH_QUAL, SQT_TY_RUNT: cand = sel_fall & qual;
      SQT_TY_DROPOUT: cand = ~drop_done_r & ~sel_lvl & (meas_r >= l1_ns);
      SQT_TY_PATTERN: cand = pat_now & ~pat_prev_r;
      default: cand = 1'b0;
    endcase
  end

  // no trigger while stopped or within holdoff
  assign fire = cand && (hold_r == 32'h0) && (run_r != SQT_RUN_STOP);
  assign auto_tick = (sweep_r == SQT_SW_AUTO) && (run_r != SQT_RUN_STOP) &&
    (idle_r == AUTO_WAIT_CYC - 32'h1) && !fire;

  // measurement, holdoff and helper state
  always_comb
  begin
    if (sel_rise || ((type_r == SQT_TY_DROPOUT) && sel_fall))
      meas_nxt = 32'h0;
    else
      meas_nxt = meas_inc;
    drop_done_nxt = (sel_rise | sel_fall) ? 1'b0 : (drop_done_r | fire);
    if (fire && (type_r == SQT_TY_EDGE) && (kind_r == SQT_KD_DELAY_HOLD))
      hold_nxt = l1_ns;
    else if (hold_r > `SQT_CLK_NS)
      hold_nxt = hold_r - `SQT_CLK_NS;
    else
      hold_nxt = 32'h0;
    pat_prev_nxt = pat_now;
    div5_nxt = div5_r;
    if (rise[5])
      div5_nxt = (div5_r == 3'h4) ? 3'h0 : div5_r + 3'h1;
  end

  // ****************************************************************
  // sweep sequencer
  // ****************************************************************
  always_comb
  begin
    run_nxt = run_r;
    idle_nxt = (fire || auto_tick) ? 32'h0 : idle_r + 32'h1;
    recv_nxt = recv_r | fire | auto_tick;
    capture_nxt = fire | auto_tick;
    unique case (run_r)
      SQT_RUN_STOP: run_nxt = SQT_RUN_STOP;
      SQT_RUN_READY:
      begin
        if (fire)
          run_nxt = (sweep_r == SQT_SW_SINGLE) ? SQT_RUN_STOP :
            SQT_RUN_TRIGD;
        else if (auto_tick)
          run_nxt = SQT_RUN_AUTO;
      end
      SQT_RUN_AUTO:
      begin
        if (fire)
          run_nxt = SQT_RUN_TRIGD;
      end
      SQT_RUN_TRIGD:
      begin
        if (fire)
          run_nxt = (sweep_r == SQT_SW_SINGLE) ? SQT_RUN_STOP : SQT_RUN_TRIGD;
        else if (auto_tick)
          run_nxt = SQT_RUN_AUTO;
        else if (sweep_r == SQT_SW_NORM && idle_r == AUTO_WAIT_CYC - 32'h1)
          run_nxt = SQT_RUN_READY;
      end
    endcase
    if (wr_in && addr_in == `SQT_ADDR_SWEEP)
    begin
      idle_nxt = 32'h0;
      capture_nxt = 1'b0;
      unique case (sqt_sweep_t'(wr_data_in[1:0]))
        SQT_SW_AUTO: run_nxt = SQT_RUN_AUTO;
        SQT_SW_NORM: run_nxt = SQT_RUN_READY;
        SQT_SW_SINGLE:
        begin
          run_nxt = SQT_RUN_READY;
          recv_nxt = 1'b0;
        end
        SQT_SW_STOP: run_nxt = SQT_RUN_STOP;
      endcase
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  // each address holds one setting, untouched by other writes
  always_comb
  begin
    sweep_nxt = sweep_r;
    type_nxt = type_r;
    src_nxt = src_r;
    kind_nxt = kind_r;
    lim1_nxt = lim1_r;
    lim2_nxt = lim2_r;
    pat_nxt = pat_r;
    cond_nxt = cond_r;
    imask_nxt = imask_r;
    reject = 1'b0;
    if (wr_in)
    begin
      unique case (addr_in)
        `SQT_ADDR_SWEEP: sweep_nxt = sqt_sweep_t'(wr_data_in[1:0]);
        `SQT_ADDR_TYPE:
        begin
          if (wr_data_in[2:0] <= 3'h6 &&
            (wr_data_in[2:0] == 3'h0 || src_r <= SQT_SRC_CH4))
            type_nxt = sqt_type_t'(wr_data_in[2:0]);
          else
            reject = 1'b1;
        end
        `SQT_ADDR_SOURCE:
        begin
          if (wr_data_in[2:0] <= 3'h3 ||
            (wr_data_in[2:0] <= 3'h6 && type_r == SQT_TY_EDGE))
            src_nxt = sqt_src_t'(wr_data_in[2:0]);
          else
            reject = 1'b1;
        end
        `SQT_ADDR_KIND:
        begin
          if (wr_data_in[3:0] <= 4'h9)
            kind_nxt = sqt_kind_t'(wr_data_in[3:0]);
          else
            reject = 1'b1;
        end
        `SQT_ADDR_LIM1: lim1_nxt = wr_data_in;
        `SQT_ADDR_LIM2: lim2_nxt = wr_data_in;
        `SQT_ADDR_PATTERN:
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (wr_data_in[`SQT_PAT_SEL_LO + i] && chan_on_in[i])
              pat_nxt[2*i +: 2] = wr_data_in[2*i +: 2];
          end
          if (wr_data_in[`SQT_PAT_COND_HI:`SQT_PAT_COND_LO] <= 2'h2)
            cond_nxt = sqt_logic_t'(wr_data_in[`SQT_PAT_COND_HI:
              `SQT_PAT_COND_LO]);
        end
        `SQT_ADDR_IRQ_MASK: imask_nxt = wr_data_in[3:0];
        default: reject = 1'b0;
      endcase
    end
  end

  // sticky events; a set in the clearing cycle wins
  assign ev = {reject, (fire && sweep_r == SQT_SW_SINGLE), auto_tick, fire};

  always_comb
  begin
    ist_nxt = ist_r;
    if (wr_in && addr_in == `SQT_ADDR_IRQ_STAT)
      ist_nxt = ist_r & ~wr_data_in[3:0];
    ist_nxt = ist_nxt | ev;
  end

  // read answer one cycle after the strobe; unmapped reads zero
  always_comb
  begin
    rd_data_nxt = 32'h0;
    if (rd_in)
    begin
      case (addr_in)
        `SQT_ADDR_SWEEP: rd_data_nxt = {30'h0, sweep_r};
        `SQT_ADDR_TYPE: rd_data_nxt = {29'h0, type_r};
        `SQT_ADDR_SOURCE: rd_data_nxt = {29'h0, src_r};
        `SQT_ADDR_KIND: rd_data_nxt = {28'h0, kind_r};
        `SQT_ADDR_LIM1: rd_data_nxt = lim1_r;
        `SQT_ADDR_LIM2: rd_data_nxt = lim2_r;
        `SQT_ADDR_PATTERN: rd_data_nxt = {18'h0, cond_r, 4'h0, pat_r};
        `SQT_ADDR_STATUS: rd_data_nxt = {28'h0, single_led_out, recv_r,
          run_r};
        `SQT_ADDR_IRQ_STAT: rd_data_nxt = {28'h0, ist_r};
        `SQT_ADDR_IRQ_MASK: rd_data_nxt = {28'h0, imask_r};
        default: rd_data_nxt = 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // state registers
  // ****************************************************************
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      sweep_r <= SQT_SW_AUTO;
      type_r <= SQT_TY_EDGE;
      src_r <= SQT_SRC_CH1;
      kind_r <= SQT_KD_OFF;
      lim1_r <= `SQT_LIM_RST;
      lim2_r <= `SQT_LIM_RST;
      pat_r <= `SQT_PAT_RST;
      cond_r <= SQT_LG_AND;
      ist_r <= 4'h0;
      imask_r <= `SQT_MASK_RST;
      rd_data_r <= 32'h0;
      run_r <= SQT_RUN_AUTO;
      idle_r <= 32'h0;
      meas_r <= 32'h0;
      hold_r <= 32'h0;
      drop_done_r <= 1'b0;
      pat_prev_r <= 1'b0;
      div5_r <= 3'h0;
      capture_r <= 1'b0;
      recv_r <= 1'b0;
    end
    else
    begin
      sweep_r <= sweep_nxt;
      type_r <= type_nxt;
      src_r <= src_nxt;
      kind_r <= kind_nxt;
      lim1_r <= lim1_nxt;
      lim2_r <= lim2_nxt;
      pat_r <= pat_nxt;
      cond_r <= cond_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      rd_data_r <= rd_data_nxt;
      run_r <= run_nxt;
      idle_r <= idle_nxt;
      meas_r <= meas_nxt;
      hold_r <= hold_nxt;
      drop_done_r <= drop_done_nxt;
      pat_prev_r <= pat_prev_nxt;
      div5_r <= div5_nxt;
      capture_r <= capture_nxt;
      recv_r <= recv_nxt;
    end
  end

  // outputs
  assign rd_data_out = rd_data_r;
  assign run_state_out = run_r;
  assign single_led_out = sweep_r == SQT_SW_SINGLE;
  assign acquiring_out = run_r != SQT_RUN_STOP;
  assign capture_out = capture_r;
  assign record_valid_out = recv_r;
  assign irq_out = |(ist_r & imask_r);

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  chk_all_dont_care: assert property (
    (type_r == SQT_TY_PATTERN && pat_r == 8'h00) |-> !fire)
    else $error("pattern with no cared channel fired");
  chk_single_halts: assert property (
    (fire && sweep_r == SQT_SW_SINGLE && !wr_in) |=>
      (run_r == SQT_RUN_STOP && capture_out) ##1 !capture_out)
    else $error("single sweep did not capture and stop");
  chk_stop_quiet: assert property (
    (run_r == SQT_RUN_STOP && !wr_in) [*2] |=> !capture_out)
    else $error("capture while stopped");
  chk_source_guard: assert property (
    type_r != SQT_TY_EDGE |-> src_r <= SQT_SRC_CH4)
    else $error("line or aux source outside edge type");
  chk_single_led: assert property (
    $rose(single_led_out) |-> run_r == SQT_RUN_READY && !record_valid_out)
    else $error("single armed without ready state");
  chk_auto_freerun: assert property (
    (auto_tick && !wr_in) |=> capture_out && run_r == SQT_RUN_AUTO)
    else $error("auto sweep did not free-run");
  chk_norm_waits: assert property (
    (sweep_r == SQT_SW_NORM && run_r == SQT_RUN_READY && !fire && !wr_in)
      |=> run_r == SQT_RUN_READY && !capture_out)
    else $error("normal sweep left ready without trigger");
  chk_holdoff_block: assert property (
    (hold_r != 32'h0) |-> !fire)
    else $error("trigger inside holdoff");
  chk_keep_others: assert property (
    (wr_in && addr_in == `SQT_ADDR_TYPE) |=>
      $stable(src_r) && $stable(kind_r) && $stable(lim1_r))
    else $error("type write disturbed another setting");
  chk_pattern_off: assert property (
    (wr_in && addr_in == `SQT_ADDR_PATTERN && !chan_on_in[0]) |=>
      $stable(pat_r[1:0]))
    else $error("pattern state taken for channel that is off");

endmodule

// ==== core/sqt_regs.svh ====
/*
  register offsets, field positions, reset values and timing counts of the
  scope trigger qualifier.
  assumes a 200 MHz system clock and a register port with 8-bit byte addresses and 32-bit data.
*/
// Contract
// - auto sweep free-runs and reports Auto without triggers, Trig'd on trigger.
// - normal sweep reports Ready until triggered, keeps last record or none.
// - single sweep lights the single indicator and waits for a trigger.
// - single sweep captures one triggered record then stops; Ready before.
// - selector takes stop besides three sweeps; stop is not a sweep mode.
// - don't-care channels leave the pattern; all don't-care never triggers.
// - low matches below threshold, high matches above threshold.
// - channel matches combine by AND, OR or NAND into the pattern trigger.
// - channel pattern state is taken only while that channel is on.
// - seven trigger types select the qualifying condition, each with qualifiers.
// - each setting is its own variable; writing one keeps all others.
// - line and aux sources only for edge type; else channels one to four.
// - width or interval compared shorter, longer, within or outside limits.
// - times limited 80 ns to 1.5 s for edge, 2 ns to 4.2 s otherwise.
// - time without unit means seconds; units select ms, us or ns.
// - query returns type, source, qualifier kind, first and second limit.
`ifndef SQT_REGS_SVH
`define SQT_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define SQT_ADDR_SWEEP 8'h00
`define SQT_ADDR_TYPE 8'h04
`define SQT_ADDR_SOURCE 8'h08
`define SQT_ADDR_KIND 8'h0c
`define SQT_ADDR_LIM1 8'h10
`define SQT_ADDR_LIM2 8'h14
`define SQT_ADDR_PATTERN 8'h18
`define SQT_ADDR_STATUS 8'h1c
`define SQT_ADDR_IRQ_STAT 8'h20
`define SQT_ADDR_IRQ_MASK 8'h24

// ****************************************************************
// field positions
// ****************************************************************
`define SQT_LIM_MANT_HI 15
`define SQT_LIM_UNIT_LO 16
`define SQT_LIM_UNIT_HI 17
`define SQT_PAT_SEL_LO 8
`define SQT_PAT_SEL_HI 11
`define SQT_PAT_COND_LO 12
`define SQT_PAT_COND_HI 13
`define SQT_IRQ_TRIG 0
`define SQT_IRQ_AUTO 1
`define SQT_IRQ_SINGLE 2
`define SQT_IRQ_REJECT 3

// ****************************************************************
// reset values
// ****************************************************************
`define SQT_LIM_RST 32'h0003_0050
`define SQT_PAT_RST 8'h00
`define SQT_MASK_RST 4'h0

// ****************************************************************
// timing
// ****************************************************************
`define SQT_CLK_NS 32'd5
`define SQT_NS_PER_S 64'd1000000000
`define SQT_NS_PER_MS 64'd1000000
`define SQT_NS_PER_US 64'd1000
`define SQT_EDGE_MIN_NS 64'd80
`define SQT_EDGE_MAX_NS 64'd1500000000
`define SQT_OTHER_MIN_NS 64'd2
`define SQT_OTHER_MAX_NS 64'd4200000000
`define SQT_AUTO_WAIT_MS 100
`define SQT_AUTO_WAIT_CYC (`SQT_AUTO_WAIT_MS * 1000000 / 5)

`endif

// ==== core/sqt_pkg.sv ====
/*
  types of the scope trigger qualifier: sweep modes, trigger types,
  sources, qualifier kinds, pattern states and run states.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sqt_pkg;

  // ****************************************************************
  // selector encodings
  // ****************************************************************
  typedef enum logic [1:0] {SQT_SW_AUTO, SQT_SW_NORM, SQT_SW_SINGLE,
    SQT_SW_STOP} sqt_sweep_t;

  typedef enum logic [2:0] {SQT_TY_EDGE, SQT_TY_EDGE_RATE, SQT_TY_WIDTH_QUAL,
    SQT_TY_GAP, SQT_TY_RUNT, SQT_TY_DROPOUT, SQT_TY_PATTERN} sqt_type_t;

  typedef enum logic [2:0] {SQT_SRC_CH1, SQT_SRC_CH2, SQT_SRC_CH3,
    SQT_SRC_CH4, SQT_SRC_LINE, SQT_SRC_AUX, SQT_SRC_AUX_DIV5} sqt_src_t;

  typedef enum logic [3:0] {SQT_KD_OFF, SQT_KD_DELAY_HOLD,
    SQT_KD_PULSE_SHORTER, SQT_KD_PULSE_LONGER, SQT_KD_PULSE_WITHIN,
    SQT_KD_PULSE_OUTSIDE, SQT_KD_GAP_SHORTER, SQT_KD_GAP_LONGER,
    SQT_KD_GAP_WITHIN, SQT_KD_GAP_OUTSIDE} sqt_kind_t;

  typedef enum logic [1:0] {SQT_UNIT_S, SQT_UNIT_MS, SQT_UNIT_US,
    SQT_UNIT_NS} sqt_unit_t;

  typedef enum logic [1:0] {SQT_LV_DONT_CARE, SQT_LV_LOW,
    SQT_LV_HIGH} sqt_lvl_t;

  typedef enum logic [1:0] {SQT_LG_AND, SQT_LG_OR, SQT_LG_NAND} sqt_logic_t;

  // ****************************************************************
  // run state
  // ****************************************************************
  typedef enum logic [1:0] {SQT_RUN_STOP, SQT_RUN_READY, SQT_RUN_AUTO,
    SQT_RUN_TRIGD} sqt_run_t;

endpackage

// ==== core/sqt_sync.sv ====
/*
  two-flop synchroniser with edge detection for one asynchronous input.
  assumes the input may change at any time relative to clk_sys_in.
*/
`timescale 1ns/1ps
module sqt_sync
(
  input wire logic clk_sys_in, // system clock
  input wire logic srst_in, // synchronous reset, high
  input wire logic async_in, // asynchronous level
  output logic level_out, // synchronised level
  output logic rise_out, // one-cycle rising pulse
  output logic fall_out // one-cycle falling pulse
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ****************************************************************
  // synchroniser and edge detector
  // ****************************************************************
  // first flop feeds only the second
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edges seen on the settled level
  assign level_out = sync_r;
  assign rise_out = sync_r & ~prev_r;
  assign fall_out = ~sync_r & prev_r;

endmodule

// ==== verification/sqt_host.sv ====
/*
  host model: single-cycle register writes and reads.
  assumes the bench shares clk_sys_in with the design.
*/
`timescale 1ns/1ps
module sqt_host
(
  input wire logic clk_sys_in, // system clock
  input wire logic [31:0] rd_data_in, // read data
  output logic [7:0] addr_out, // byte address
  output logic [31:0] wr_data_out, // write data
  output logic wr_out, // write strobe
  output logic rd_out // read strobe
);
  // idle bus
  initial
  begin
    addr_out = 8'h00;
    wr_data_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one write; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_sys_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
    #1;
  endtask
  // one read; data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rd_data_in;
  endtask
endmodule

// ==== verification/tb_top.sv ====
/*
  bench: register rows, interrupt, pattern trigger, sweep modes,
  pulse width qualifier and a reset once the single sweep has stopped.
  assumes sqt_host owns the register port.
*/
`timescale 1ns/1ps
module tb_top;
  import sqt_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic [3:0] above = 4'h0;
  logic [3:0] on = 4'h1;
  logic [7:0] a;
  logic [31:0] wd, rdat, v;
  logic w, r, irq, led, acq, cap, rv;
  sqt_run_t run;
  int error_cnt = 0;
  int num_checks = 0;
  // write addr, data, read addr, expected
  logic [31:0] rows [9][4] = '{'{4, 0, 4, 0}, '{8, 4, 8, 4},
    '{4, 1, 4, 0}, '{8, 1, 8, 1}, '{4, 7, 4, 0}, '{4, 6, 4, 6},
    '{12, 4, 12, 4}, '{48, 255, 48, 0}, '{48, 0, 16, 32'h0003_0050}};
  // pattern word, level before arming, level after
  logic [31:0] pats [3][3] = '{'{32'h0102, 0, 1}, '{32'h1101, 1, 0},
    '{32'h2102, 1, 0}};
  always #2.5 clk_sys_in = ~clk_sys_in;
  sqt_host host_u (.clk_sys_in(clk_sys_in), .rd_data_in(rdat),
    .addr_out(a), .wr_data_out(wd), .wr_out(w), .rd_out(r));
  sqt_top #(.AUTO_WAIT_CYC(32'd32)) dut_u (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .chan_above_in(above), .chan_on_in(on),
    .line_in(1'b0), .aux_in(1'b0), .addr_in(a), .wr_data_in(wd),
    .wr_in(w), .rd_in(r), .rd_data_out(rdat), .run_state_out(run),
    .single_led_out(led), .acquiring_out(acq), .capture_out(cap),
    .record_valid_out(rv), .irq_out(irq));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait for a capture pulse
  task automatic wait_cap();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    while (cap !== 1'b1 && n < 200);
    if (cap !== 1'b1)
    begin
      chk({31'h0, cap}, 32'h1);
      conclude();
    end
  endtask
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    #1;
    chk({30'h0, run}, 32'h2);
    for (int i = 0; i < 9; i++)
    begin
      host_u.wr(rows[i][0][7:0], rows[i][1]);
      host_u.rd(rows[i][2][7:0], v);
      chk(v, rows[i][3]);
    end
    host_u.wr(8'h24, 32'h8);
    chk({31'h0, irq}, 32'h1);
    host_u.wr(8'h20, 32'h8);
    chk({31'h0, irq}, 32'h0);
    host_u.wr(8'h18, 32'h0102);
    host_u.wr(8'h18, 32'h0208);
    host_u.rd(8'h18, v);
    chk(v, 32'h02);
    for (int i = 0; i < 3; i++)
    begin
      host_u.wr(8'h18, pats[i][0]);
      @(posedge clk_sys_in);
      above <= pats[i][1][3:0];
      repeat (5) @(posedge clk_sys_in);
      host_u.wr(8'h00, 32'h2);
      chk({29'h0, led, run}, 32'h5);
      @(posedge clk_sys_in);
      above <= pats[i][2][3:0];
      wait_cap();
      chk({29'h0, rv, run}, 32'h4);
    end
    host_u.wr(8'h00, 32'h3);
    chk({29'h0, acq, run}, 32'h0);
    host_u.wr(8'h18, 32'h0100);
    host_u.wr(8'h00, 32'h1);
    @(posedge clk_sys_in);
    above <= 4'h1;
    repeat (40) @(posedge clk_sys_in);
    #1;
    chk({30'h0, run}, 32'h1);
    // pulse within 10 ns .. 100 ns on channel one, single sweep
    @(posedge clk_sys_in);
    above <= 4'h0;
    host_u.wr(8'h04, 32'h2);
    host_u.wr(8'h08, 32'h0);
    host_u.wr(8'h0c, 32'h4);
    host_u.wr(8'h10, 32'h0003_000a);
    host_u.wr(8'h14, 32'h0003_0064);
    host_u.wr(8'h00, 32'h2);
    @(posedge clk_sys_in);
    above <= 4'h1;
    repeat (10) @(posedge clk_sys_in);
    above <= 4'h0;
    wait_cap();
    chk({29'h0, rv, run}, 32'h4);
    // reset while stopped after single sweep, then auto sweep free-runs
    @(posedge clk_sys_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    #1;
    chk({26'h0, cap, rv, acq, led, irq, run}, 32'h12);
    chk(rdat, 32'h0);
    host_u.rd(8'h04, v);
    chk(v, 32'h0);
    wait_cap();
    chk({29'h0, rv, run}, 32'h6);
    conclude();
  end
endmodule
